// ---- src/rwc_pkg.sv ----
package rwc_pkg;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned STRAP_W = 4;

	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 16'h0126;
	localparam logic [ADDR_W-1:0] WAKE_OFFSET = 16'h012a;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 16'h012c;

	localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] WAKE_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] WAKE_WRITE_MASK = 16'h008f;

	localparam int unsigned CTRL_GLOBAL_BIT = 0;
	localparam int unsigned CTRL_QUEUE_BIT = 1;
	localparam int unsigned CTRL_SELF_TEST_BIT = 3;

	localparam int unsigned WAKE_PATTERN0_BIT = 0;
	localparam int unsigned WAKE_PATTERN1_BIT = 1;
	localparam int unsigned WAKE_PATTERN2_BIT = 2;
	localparam int unsigned WAKE_PATTERN3_BIT = 3;
	localparam int unsigned WAKE_PACKET_BIT = 7;

	localparam int unsigned STAT_ELAPSED_BIT = 0;
	localparam int unsigned STAT_GLOBAL_BIT = 1;
	localparam int unsigned STAT_QUEUE_BIT = 2;
	localparam int unsigned STAT_STRAP_LSB = 8;

	localparam int unsigned CLOCK_HZ = 20_000_000;
	localparam int unsigned SOFT_RESET_HOLD_MS = 10;
	localparam int unsigned SOFT_RESET_HOLD_CYCLES = (CLOCK_HZ / 1000) * SOFT_RESET_HOLD_MS;

	typedef enum logic [1:0] {
		TMR_IDLE,
		TMR_COUNT,
		TMR_DONE
	} rwc_timer_state_t;
endpackage

// ---- src/rwc_strap_latch.sv ----
`timescale 1ns/1ns
module rwc_strap_latch #(
	parameter int unsigned WIDTH = rwc_pkg::STRAP_W
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic [WIDTH-1:0] i_strap,
	output logic [WIDTH-1:0] o_strap_value
);
	import rwc_pkg::*;

	typedef struct packed {
		logic armed;
		logic [WIDTH-1:0] value;
	} rwc_strap_state_t;

	rwc_strap_state_t state_reg;
	rwc_strap_state_t state_next;

	// captured once after hardware reset release; soft reset never reaches here
	always_comb begin
		state_next = state_reg;
		if (!state_reg.armed) begin
			state_next.armed = 1'b1;
			state_next.value = i_strap;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_strap_value = state_reg.value;
endmodule

// ---- src/rwc_hold_timer.sv ----
`timescale 1ns/1ns
module rwc_hold_timer #(
	parameter int unsigned HOLD_CYCLES = rwc_pkg::SOFT_RESET_HOLD_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_hold,
	output logic o_elapsed
);
	import rwc_pkg::*;

	localparam int unsigned CNT_W = $clog2(HOLD_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HOLD_CYCLES);

	typedef struct packed {
		rwc_timer_state_t fsm;
		logic [CNT_W-1:0] count;
	} rwc_timer_reg_t;

	rwc_timer_reg_t state_reg;
	rwc_timer_reg_t state_next;

	// informs software when the soft reset has been held long enough
	always_comb begin
		state_next = state_reg;
		case (state_reg.fsm)
			TMR_IDLE: begin
				if (i_hold) begin
					state_next.fsm = TMR_COUNT;
					state_next.count = CNT_ONE;
				end
			end
			TMR_COUNT: begin
				if (!i_hold) begin
					state_next.fsm = TMR_IDLE;
				end else if (state_reg.count >= CNT_LAST) begin
					state_next.fsm = TMR_DONE;
				end else begin
					state_next.count = state_reg.count + CNT_ONE;
				end
			end
			TMR_DONE: begin
				if (!i_hold) begin
					state_next.fsm = TMR_IDLE;
				end
			end
			default: begin
				state_next.fsm = TMR_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= '{fsm: TMR_IDLE, count: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_elapsed = (state_reg.fsm == TMR_DONE);
endmodule

// ---- src/rwc_top.sv ----
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
module rwc_top #(
	parameter int unsigned HOLD_CYCLES = rwc_pkg::SOFT_RESET_HOLD_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic [rwc_pkg::ADDR_W-1:0] i_addr,
	input wire logic [rwc_pkg::DATA_W-1:0] i_wr_data,
	input wire logic i_wr_strobe,
	input wire logic i_rd_strobe,
	input wire logic [rwc_pkg::STRAP_W-1:0] i_strap,
	output logic [rwc_pkg::DATA_W-1:0] o_rd_data,
	output logic o_memory_self_test_run,
	output logic o_queue_manager_reset,
	output logic o_transmit_queue_memory_clear,
	output logic o_receive_queue_memory_clear,
	output logic o_global_soft_reset,
	output logic o_wake_packet_detect_enable,
	output logic o_pattern0_detect_enable,
	output logic o_pattern1_detect_enable,
	output logic o_pattern2_detect_enable,
	output logic o_pattern3_detect_enable,
	output logic [rwc_pkg::STRAP_W-1:0] o_strap_value
);
	import rwc_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] ctrl;
		logic [DATA_W-1:0] wake;
		logic [DATA_W-1:0] rd_data;
		logic queue_reset;
	} rwc_top_state_t;

	rwc_top_state_t state_reg;
	rwc_top_state_t state_next;
	logic hold_elapsed;
	logic [STRAP_W-1:0] strap_value;
	logic wr_ctrl;
	logic wr_wake;
	logic rd_wake;
	logic rd_ctrl;
	logic rd_status;

	function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] offset);
		addr_hit = (addr == offset);
	endfunction

	assign wr_ctrl = i_wr_strobe && addr_hit(i_addr, CTRL_OFFSET);
	assign wr_wake = i_wr_strobe && addr_hit(i_addr, WAKE_OFFSET);
	assign rd_ctrl = i_rd_strobe && addr_hit(i_addr, CTRL_OFFSET);
	assign rd_wake = i_rd_strobe && addr_hit(i_addr, WAKE_OFFSET);
	assign rd_status = i_rd_strobe && addr_hit(i_addr, STATUS_OFFSET);

	rwc_strap_latch #(
		.WIDTH(STRAP_W)
	) i_rwc_strap_latch (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_strap(i_strap),
		.o_strap_value(strap_value)
	);

	rwc_hold_timer #(
		.HOLD_CYCLES(HOLD_CYCLES)
	) i_rwc_hold_timer (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_hold(state_reg.ctrl[CTRL_GLOBAL_BIT]),
		.o_elapsed(hold_elapsed)
	);

	function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] addr,
		input rwc_top_state_t s, input logic elapsed, input logic [STRAP_W-1:0] strap);
		logic [DATA_W-1:0] status;
		status = '0;
		status[STAT_ELAPSED_BIT] = elapsed;
		status[STAT_GLOBAL_BIT] = s.ctrl[CTRL_GLOBAL_BIT];
		status[STAT_QUEUE_BIT] = s.queue_reset;
		status[STAT_STRAP_LSB +: STRAP_W] = strap;
		if (addr_hit(addr, CTRL_OFFSET)) begin
			read_mux = s.ctrl;
		end else if (addr_hit(addr, WAKE_OFFSET)) begin
			read_mux = s.wake & WAKE_WRITE_MASK;
		end else if (addr_hit(addr, STATUS_OFFSET)) begin
			read_mux = status;
		end else begin
			read_mux = '0;
		end
	endfunction

	always_comb begin
		state_next = state_reg;
		state_next.rd_data = '0;
		if (wr_ctrl) begin
			state_next.ctrl = i_wr_data;
		end
		if (wr_wake) begin
			// reserved bits masked at write time, so they can never be set
			state_next.wake = i_wr_data & WAKE_WRITE_MASK;
		end
		if (state_next.ctrl[CTRL_GLOBAL_BIT]) begin
			// control and wake registers held at default while active, except the bit itself
			state_next.ctrl = CTRL_RESET;
			state_next.ctrl[CTRL_GLOBAL_BIT] = 1'b1;
			state_next.wake = WAKE_RESET;
		end
		// global soft reset also resets the queue manager
		state_next.queue_reset = state_next.ctrl[CTRL_QUEUE_BIT]
			| state_next.ctrl[CTRL_GLOBAL_BIT];
		if (i_rd_strobe) begin
			state_next.rd_data = read_mux(i_addr, state_reg, hold_elapsed, strap_value);
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= '{ctrl: CTRL_RESET, wake: WAKE_RESET, rd_data: '0, queue_reset: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_rd_data = state_reg.rd_data;
	assign o_memory_self_test_run = state_reg.ctrl[CTRL_SELF_TEST_BIT];
	assign o_queue_manager_reset = state_reg.queue_reset;
	assign o_transmit_queue_memory_clear = state_reg.queue_reset;
	assign o_receive_queue_memory_clear = state_reg.queue_reset;
	assign o_global_soft_reset = state_reg.ctrl[CTRL_GLOBAL_BIT];
	assign o_wake_packet_detect_enable = state_reg.wake[WAKE_PACKET_BIT];
	assign o_pattern0_detect_enable = state_reg.wake[WAKE_PATTERN0_BIT];
	assign o_pattern1_detect_enable = state_reg.wake[WAKE_PATTERN1_BIT];
	assign o_pattern2_detect_enable = state_reg.wake[WAKE_PATTERN2_BIT];
	assign o_pattern3_detect_enable = state_reg.wake[WAKE_PATTERN3_BIT];
	assign o_strap_value = strap_value;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_b);

	chk_self_test_start: assert property (
		wr_ctrl && i_wr_data[CTRL_SELF_TEST_BIT] && !i_wr_data[CTRL_GLOBAL_BIT]
		|=> o_memory_self_test_run)
		else $error("self-test did not start");

	chk_self_test_stop: assert property (
		wr_ctrl && !i_wr_data[CTRL_SELF_TEST_BIT] |=> !o_memory_self_test_run)
		else $error("self-test did not stop");

	chk_queue_reset_hold: assert property (
		wr_ctrl && i_wr_data[CTRL_QUEUE_BIT]
		|=> o_queue_manager_reset && o_transmit_queue_memory_clear
		&& o_receive_queue_memory_clear)
		else $error("queue reset not applied");

	chk_queue_reset_free: assert property (
		!state_reg.ctrl[CTRL_QUEUE_BIT] && !o_global_soft_reset |-> !o_queue_manager_reset)
		else $error("queue reset without cause");

	chk_global_defaults: assert property (
		o_global_soft_reset |-> state_reg.wake == WAKE_RESET
		&& (state_reg.ctrl >> 1) == (CTRL_RESET >> 1) && o_queue_manager_reset)
		else $error("registers not at default during soft reset");

	chk_strap_kept: assert property (
		o_global_soft_reset && $past(o_global_soft_reset) |-> $stable(o_strap_value))
		else $error("strap value changed under soft reset");

	chk_global_sticky: assert property (
		o_global_soft_reset && !wr_ctrl |=> o_global_soft_reset)
		else $error("soft reset bit cleared by hardware");

	chk_global_release: assert property (
		wr_ctrl && !i_wr_data[CTRL_GLOBAL_BIT] |=> !o_global_soft_reset ##1 !hold_elapsed)
		else $error("soft reset release not honoured");

	chk_wake_packet: assert property (
		wr_wake && !o_global_soft_reset
		|=> o_wake_packet_detect_enable == $past(i_wr_data[WAKE_PACKET_BIT]))
		else $error("wake packet enable wrong");

	chk_pattern_enables: assert property (
		wr_wake && !o_global_soft_reset
		|=> {o_pattern3_detect_enable, o_pattern2_detect_enable,
		o_pattern1_detect_enable, o_pattern0_detect_enable}
		== $past(i_wr_data[WAKE_PATTERN3_BIT:WAKE_PATTERN0_BIT]))
		else $error("pattern enable wrong");

	chk_wake_reserved: assert property (
		rd_wake |=> (o_rd_data & ~WAKE_WRITE_MASK) == '0)
		else $error("wake reserved bits read nonzero");

	chk_ctrl_readback: assert property (
		rd_ctrl |=> o_rd_data[CTRL_GLOBAL_BIT] == $past(o_global_soft_reset))
		else $error("control readback wrong");

	chk_self_test_keep: assert property (
		!wr_ctrl |=> $stable(o_memory_self_test_run))
		else $error("self-test changed without a write");

	chk_self_test_global: assert property (
		o_global_soft_reset |-> !o_memory_self_test_run)
		else $error("self-test running during soft reset");

	chk_queue_release: assert property (
		wr_ctrl && !i_wr_data[CTRL_QUEUE_BIT] && !i_wr_data[CTRL_GLOBAL_BIT]
		|=> !o_queue_manager_reset)
		else $error("queue reset not released");

	chk_queue_clear_on: assert property (
		o_queue_manager_reset |-> o_transmit_queue_memory_clear && o_receive_queue_memory_clear)
		else $error("queue memories not cleared");

	chk_queue_clear_off: assert property (
		!o_queue_manager_reset
		|-> !o_transmit_queue_memory_clear && !o_receive_queue_memory_clear)
		else $error("queue memory clear without reset");

	chk_queue_by_global: assert property (
		wr_ctrl && i_wr_data[CTRL_GLOBAL_BIT] |=> o_queue_manager_reset)
		else $error("queue not reset by soft reset");

	chk_global_set: assert property (
		wr_ctrl && i_wr_data[CTRL_GLOBAL_BIT] |=> o_global_soft_reset)
		else $error("soft reset did not activate");

	chk_global_wake_off: assert property (
		wr_ctrl && i_wr_data[CTRL_GLOBAL_BIT] |=> !o_wake_packet_detect_enable
		&& !o_pattern0_detect_enable && !o_pattern1_detect_enable
		&& !o_pattern2_detect_enable && !o_pattern3_detect_enable)
		else $error("wake enables kept under soft reset");

	chk_wake_blocked: assert property (
		wr_wake && o_global_soft_reset |=> state_reg.wake == WAKE_RESET)
		else $error("wake write landed during soft reset");

	chk_ctrl_blocked: assert property (
		wr_ctrl && i_wr_data[CTRL_GLOBAL_BIT] |=> (state_reg.ctrl >> 1) == (CTRL_RESET >> 1))
		else $error("control bits not at default under soft reset");

	chk_strap_fixed: assert property (
		$past(i_rst_b, 2) |-> $stable(o_strap_value))
		else $error("strap value changed after capture");

	chk_global_rewrite: assert property (
		o_global_soft_reset && wr_ctrl && i_wr_data[CTRL_GLOBAL_BIT] |=> o_global_soft_reset)
		else $error("soft reset dropped on rewrite");

	chk_ctrl_stored: assert property (
		wr_ctrl && !i_wr_data[CTRL_GLOBAL_BIT] |=> state_reg.ctrl == $past(i_wr_data))
		else $error("control write not stored");

	chk_elapsed_drop: assert property (
		!o_global_soft_reset |=> !hold_elapsed)
		else $error("hold elapsed without soft reset");

	chk_elapsed_early: assert property (
		$rose(o_global_soft_reset) |-> !hold_elapsed ##1 !hold_elapsed)
		else $error("hold elapsed too early");

	chk_wake_keep: assert property (
		!wr_wake && !(wr_ctrl && i_wr_data[CTRL_GLOBAL_BIT])
		|=> $stable(state_reg.wake))
		else $error("wake enables changed without a write");

	chk_wake_readback: assert property (
		rd_wake |=> o_rd_data == $past(state_reg.wake))
		else $error("wake readback wrong");

	chk_ctrl_read_all: assert property (
		rd_ctrl |=> o_rd_data == $past(state_reg.ctrl))
		else $error("control readback word wrong");

	chk_status_elapsed: assert property (
		rd_status |=> o_rd_data[STAT_ELAPSED_BIT] == $past(hold_elapsed))
		else $error("status elapsed bit wrong");

	chk_status_strap: assert property (
		rd_status |=> o_rd_data[STAT_STRAP_LSB +: STRAP_W] == $past(o_strap_value))
		else $error("status strap field wrong");

	chk_status_global: assert property (
		rd_status |=> o_rd_data[STAT_GLOBAL_BIT] == $past(o_global_soft_reset))
		else $error("status soft reset bit wrong");

	chk_status_queue: assert property (
		rd_status |=> o_rd_data[STAT_QUEUE_BIT] == $past(o_queue_manager_reset))
		else $error("status queue bit wrong");

	chk_wake_write_mask: assert property (
		wr_wake |=> (state_reg.wake & ~WAKE_WRITE_MASK) == '0)
		else $error("wake reserved bits stored");

	chk_pattern0_write: assert property (
		wr_wake && !o_global_soft_reset
		|=> o_pattern0_detect_enable == $past(i_wr_data[WAKE_PATTERN0_BIT]))
		else $error("pattern 0 enable wrong");

	chk_pattern1_write: assert property (
		wr_wake && !o_global_soft_reset
		|=> o_pattern1_detect_enable == $past(i_wr_data[WAKE_PATTERN1_BIT]))
		else $error("pattern 1 enable wrong");

	chk_pattern2_write: assert property (
		wr_wake && !o_global_soft_reset
		|=> o_pattern2_detect_enable == $past(i_wr_data[WAKE_PATTERN2_BIT]))
		else $error("pattern 2 enable wrong");

	chk_pattern3_write: assert property (
		wr_wake && !o_global_soft_reset
		|=> o_pattern3_detect_enable == $past(i_wr_data[WAKE_PATTERN3_BIT]))
		else $error("pattern 3 enable wrong");

	chk_wake_packet_off: assert property (
		wr_wake && !i_wr_data[WAKE_PACKET_BIT] |=> !o_wake_packet_detect_enable)
		else $error("wake packet enable not cleared");

	chk_wake_read_global: assert property (
		rd_wake && o_global_soft_reset |=> o_rd_data == WAKE_RESET)
		else $error("wake read not default under soft reset");

	chk_ctrl_read_global: assert property (
		rd_ctrl && o_global_soft_reset |=> (o_rd_data >> 1) == (CTRL_RESET >> 1))
		else $error("control read not default under soft reset");

	chk_wake_packet_on: assert property (
		wr_wake && !o_global_soft_reset && i_wr_data[WAKE_PACKET_BIT]
		|=> o_wake_packet_detect_enable)
		else $error("wake packet enable not set");

	chk_queue_hold_keep: assert property (
		o_queue_manager_reset && !wr_ctrl |=> o_queue_manager_reset)
		else $error("queue reset dropped without a write");

	chk_global_held_off: assert property (
		!o_global_soft_reset && !wr_ctrl |=> !o_global_soft_reset)
		else $error("soft reset rose without a write");

	chk_self_test_cut: assert property (
		wr_ctrl && i_wr_data[CTRL_GLOBAL_BIT] |=> !o_memory_self_test_run)
		else $error("self-test kept through soft reset");

	cov_soft_reset: cover property ($rose(o_global_soft_reset));
	cov_hold_done: cover property (o_global_soft_reset && hold_elapsed ##1 wr_ctrl);
	cov_queue_reset: cover property ($rose(o_queue_manager_reset) && !o_global_soft_reset);
	cov_wake_all: cover property (o_wake_packet_detect_enable && o_pattern3_detect_enable);
	cov_wake_blocked: cover property (wr_wake && o_global_soft_reset);
endmodule

// ---- bench/reset_and_wake_control_tb.sv ----
`timescale 1ns/1ns
module reset_and_wake_control_tb;
	import rwc_pkg::*;
	localparam int unsigned HOLD = 8;
	logic i_clock = 1'b0;
	logic i_rst_b = 1'b0;
	logic [ADDR_W-1:0] i_addr = 16'h0000;
	logic [DATA_W-1:0] i_wr_data = 16'h0000;
	logic i_wr_strobe = 1'b0;
	logic i_rd_strobe = 1'b0;
	logic [STRAP_W-1:0] i_strap = 4'ha;
	logic [DATA_W-1:0] o_rd_data;
	logic o_st, o_qm, o_txc, o_rxc, o_gsr, o_wp, o_p0, o_p1, o_p2, o_p3;
	logic [STRAP_W-1:0] o_strap_value;
	int error_cnt = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [DATA_W-1:0] rd;
	rwc_top #(.HOLD_CYCLES(HOLD)) i_rwc_top (.i_clock(i_clock), .i_rst_b(i_rst_b),
		.i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_strobe(i_wr_strobe),
		.i_rd_strobe(i_rd_strobe), .i_strap(i_strap), .o_rd_data(o_rd_data),
		.o_memory_self_test_run(o_st), .o_queue_manager_reset(o_qm),
		.o_transmit_queue_memory_clear(o_txc), .o_receive_queue_memory_clear(o_rxc),
		.o_global_soft_reset(o_gsr), .o_wake_packet_detect_enable(o_wp),
		.o_pattern0_detect_enable(o_p0), .o_pattern1_detect_enable(o_p1),
		.o_pattern2_detect_enable(o_p2), .o_pattern3_detect_enable(o_p3),
		.o_strap_value(o_strap_value));
	initial begin
		forever #25 i_clock = ~i_clock;
	end
	// generous ceiling; the whole run needs about a hundred cycles
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			error_cnt = error_cnt + 1;
			finish_test();
		end
	end
	task automatic finish_test();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp,
			input string msg);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("ERROR at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge i_clock);
		i_wr_strobe <= 1'b1;
		i_addr <= a;
		i_wr_data <= d;
		@(posedge i_clock);
		i_wr_strobe <= 1'b0;
		#1;
	endtask
	// read data stand only in the cycle after the strobe, so sample just then
	task automatic rdr(input logic [ADDR_W-1:0] a);
		@(posedge i_clock);
		i_rd_strobe <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd_strobe <= 1'b0;
		#1;
		rd = o_rd_data;
	endtask
	function automatic logic [DATA_W-1:0] outs();
		return {6'h00, o_gsr, o_qm, o_txc, o_rxc, o_st, o_wp, o_p3, o_p2, o_p1, o_p0};
	endfunction
	task automatic t_reset_values();
		chk(outs(), 16'h0000, "outputs after reset");
		rdr(WAKE_OFFSET);
		chk(rd, WAKE_RESET, "wake reset value");
		rdr(CTRL_OFFSET);
		chk(rd, CTRL_RESET, "control reset value");
		rdr(16'h0128);
		chk(rd, 16'h0000, "unmapped read");
	endtask
	task automatic t_control();
		wr(CTRL_OFFSET, 16'h0008);
		chk(outs(), 16'h0020, "self-test start");
		wr(CTRL_OFFSET, 16'hfffa);
		chk(outs(), 16'h01e0, "queue manager reset held");
		rdr(CTRL_OFFSET);
		chk(rd, 16'hfffa, "control readback");
		wr(CTRL_OFFSET, 16'h0000);
		chk(outs(), 16'h0000, "self-test stop, queue reset off");
	endtask
	task automatic t_wake();
		int bits[5] = '{0, 1, 2, 3, 7};
		foreach (bits[k]) begin
			wr(WAKE_OFFSET, 16'h0001 << bits[k]);
			chk(outs(), bits[k] == 7 ? 16'h0010 : 16'h0001 << bits[k],
				"wake enable output");
			rdr(WAKE_OFFSET);
			chk(rd, 16'h0001 << bits[k], "wake readback");
		end
		wr(WAKE_OFFSET, 16'hffff);
		rdr(WAKE_OFFSET);
		chk(rd, 16'h008f, "wake reserved bits");
		wr(16'h0128, 16'h0000);
		rdr(WAKE_OFFSET);
		chk(rd, 16'h008f, "unmapped write ignored");
		wr(WAKE_OFFSET, 16'h0070);
		chk(outs(), 16'h0000, "reserved-only write");
	endtask
	task automatic t_soft_reset();
		wr(WAKE_OFFSET, 16'h008f);
		wr(CTRL_OFFSET, 16'h0008);
		wr(CTRL_OFFSET, 16'h0009);
		chk(outs(), 16'h03c0, "soft reset clears registers");
		wr(WAKE_OFFSET, 16'h0081);
		rdr(WAKE_OFFSET);
		chk(rd, 16'h0000, "wake held during soft reset");
		rdr(STATUS_OFFSET);
		chk(rd, 16'h0a06, "status before hold elapsed");
		wr(CTRL_OFFSET, 16'h000b);
		chk(outs(), 16'h03c0, "soft reset kept on rewrite");
		// the bit must survive well past the hold count
		repeat (HOLD + 6) @(posedge i_clock);
		#1;
		chk({15'h0000, o_gsr}, 16'h0001, "soft reset not self-clearing");
		rdr(CTRL_OFFSET);
		chk(rd, 16'h0001, "control during soft reset");
		rdr(STATUS_OFFSET);
		chk(rd, 16'h0a07, "status after hold");
		chk({12'h000, o_strap_value}, 16'h000a, "straps kept");
		wr(CTRL_OFFSET, 16'h0000);
		chk(outs(), 16'h0000, "normal operation");
		rdr(WAKE_OFFSET);
		chk(rd, WAKE_RESET, "wake default after soft reset");
		wr(WAKE_OFFSET, 16'h0004);
		chk(outs(), 16'h0004, "writes land again");
	endtask
	initial begin
		repeat (12) @(posedge i_clock);
		i_rst_b <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_strap <= 4'h5;
		#1;
		chk({12'h000, o_strap_value}, 16'h000a, "strap capture");
		t_reset_values();
		t_control();
		t_wake();
		t_soft_reset();
		finish_test();
	end
endmodule
